/* sacc_pkg.sv */
// Package: constants, types and state layout of the converter control
package sacc_pkg;

  // Clock and conversion figures
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned MAX_SPS    = 500_000;

  // Widths
  localparam int unsigned CODE_W = 10;
  localparam int unsigned DIV_W  = 5;
  localparam int unsigned RES_W  = 16;
  localparam int unsigned TRK_W  = 2;
  localparam int unsigned IDX_W  = 4;
  localparam int unsigned PAD_W  = RES_W - CODE_W;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG  = 8'h04;
  localparam logic [7:0] OFS_RESH = 8'h08;
  localparam logic [7:0] OFS_RESL = 8'h0c;
  localparam logic [7:0] OFS_MISC = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_EN     = 7;
  localparam int unsigned CTRL_TM     = 6;
  localparam int unsigned CTRL_DONE   = 5;
  localparam int unsigned CTRL_BUSY   = 4;
  localparam int unsigned CTRL_SRC_LO = 0;
  localparam int unsigned SRC_W       = 3;

  // Configuration register fields
  localparam int unsigned CFG_DIV_LO = 3;
  localparam int unsigned CFG_LJST   = 2;
  localparam logic [DIV_W-1:0] CFG_DIV_RST = 5'h1f;

  // Mode register fields
  localparam int unsigned MISC_DIFF   = 0;
  localparam int unsigned MISC_STBY   = 1;
  localparam int unsigned MISC_T16_LO = 2;
  localparam int unsigned NUM_XTMR    = 4;

  // Start source codes
  localparam logic [SRC_W-1:0] SRC_SW  = 3'h0;
  localparam logic [SRC_W-1:0] SRC_T0  = 3'h1;
  localparam logic [SRC_W-1:0] SRC_T2  = 3'h2;
  localparam logic [SRC_W-1:0] SRC_T1  = 3'h3;
  localparam logic [SRC_W-1:0] SRC_PIN = 3'h4;
  localparam logic [SRC_W-1:0] SRC_T3  = 3'h5;
  localparam logic [SRC_W-1:0] SRC_T4  = 3'h6;
  localparam logic [SRC_W-1:0] SRC_T5  = 3'h7;

  // Sequencing
  localparam logic [TRK_W-1:0]  TRACK_SAR_CLKS = 2'h3;
  localparam logic [TRK_W-1:0]  TRK_LAST = TRACK_SAR_CLKS - 2'h1;
  localparam logic [IDX_W-1:0]  IDX_MSB  = 4'h9;
  localparam logic [CODE_W-1:0] TRIAL_INIT = 10'h200;

  typedef enum logic [1:0] {
    SACC_IDLE, SACC_TRACK, SACC_CONV, SACC_DONE
  } sacc_fsm_t;

  // Timer overflow strobes; lo/hi are timers 2..5
  typedef struct packed {
    logic                t0;
    logic                t1;
    logic [NUM_XTMR-1:0] lo;
    logic [NUM_XTMR-1:0] hi;
  } sacc_tmr_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } sacc_sync_t;

  typedef struct packed {
    logic                en;
    logic                tm;
    logic                done;
    logic [SRC_W-1:0]    src;
    logic [DIV_W-1:0]    div;
    logic                ljst;
    logic                diff;
    logic                stby_off;
    logic [NUM_XTMR-1:0] t16;
    logic [RES_W-1:0]    res;
    sacc_fsm_t           fsm;
    logic [DIV_W-1:0]    div_cnt;
    logic [TRK_W-1:0]    trk_cnt;
    logic [IDX_W-1:0]    idx;
    logic [CODE_W-1:0]   code;
    logic                pin_d;
    logic [31:0]         prdata;
    logic                pslverr;
  } sacc_state_t;

endpackage : sacc_pkg

/* sacc_sync.sv */
// Two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module sacc_sync
  import sacc_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Level in and out
  input  wire logic async_in,
  output logic      sync_out
);

  sacc_sync_t st_r;
  sacc_sync_t st_nxt;

  always_comb begin
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;

endmodule : sacc_sync
`default_nettype wire

/* sacc_fmt.sv */
// Result formatter: sign, justification and padding of the code
`timescale 1ns/1ps
`default_nettype none
module sacc_fmt
  import sacc_pkg::*;
(
  // Raw SAR code and format select
  input  wire logic [CODE_W-1:0] code,
  input  wire logic              ljst,
  input  wire logic              diff,
  // Formatted result word
  output logic      [RES_W-1:0]  res
);

  logic [CODE_W-1:0] val;

  always_comb begin
    val = code;
    if (diff) begin
      val[CODE_W-1] = ~code[CODE_W-1];
    end
    if (ljst) begin
      res = {val, {PAD_W{1'b0}}};
    end else if (diff) begin
      res = {{PAD_W{val[CODE_W-1]}}, val};
    end else begin
      res = {{PAD_W{1'b0}}, val};
    end
  end

endmodule : sacc_fmt
`default_nettype wire

/* sacc_top.sv */
// Converter control: APB registers, start select, track and SAR sequencing
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sacc_top
  import sacc_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // Start triggers and standby
  input  wire sacc_tmr_t         tmr_ovf,
  input  wire logic              external_start_pin,
  input  wire logic              standby,
  // Analog converter side
  input  wire logic              cmp_in,
  output logic                   analog_enable,
  output logic                   track_enable,
  output logic                   sar_strobe,
  output logic      [CODE_W-1:0] dac_code
);

  sacc_state_t         st_r;
  sacc_state_t         st_nxt;
  logic                pin_s;
  logic [RES_W-1:0]    fmt_res;
  logic                wr;
  logic                sw_trig;
  logic                hw_trig;
  logic                trig;
  logic                lp_pin;
  logic                sar_tick;
  logic                trk;
  logic                busy;
  logic [NUM_XTMR-1:0] xtmr;
  logic [IDX_W-1:0]    nidx;
  logic [31:0]         rdata;
  logic                hit;

  sacc_sync u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (external_start_pin),
    .sync_out (pin_s)
  );

  sacc_fmt u_fmt (
    .code (st_r.code),
    .ljst (st_r.ljst),
    .diff (st_r.diff),
    .res  (fmt_res)
  );

  assign busy = (st_r.fsm != SACC_IDLE);

  always_comb begin
    st_nxt   = st_r;
    wr       = psel & penable & pwrite;
    sar_tick = 1'b0;
    hw_trig  = 1'b0;
    nidx     = st_r.idx - 4'h1;
    rdata    = '0;
    hit      = 1'b1;
    trk      = 1'b0;

    // SAR clock tick from the system clock
    // Period of divider field plus one
    if (!st_r.en) begin
      st_nxt.div_cnt = '0;
    end else if (st_r.div_cnt >= st_r.div) begin
      st_nxt.div_cnt = '0;
      sar_tick       = 1'b1;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 5'h1;
    end

    // Register writes in the access phase
    if (wr) begin
      unique case (paddr)
        OFS_CTRL: begin
          st_nxt.en   = pwdata[CTRL_EN];
          st_nxt.tm   = pwdata[CTRL_TM];
          st_nxt.done = pwdata[CTRL_DONE];
          st_nxt.src  = pwdata[CTRL_SRC_LO +: SRC_W];
        end
        OFS_CFG: begin
          st_nxt.div  = pwdata[CFG_DIV_LO +: DIV_W];
          st_nxt.ljst = pwdata[CFG_LJST];
        end
        OFS_MISC: begin
          st_nxt.diff     = pwdata[MISC_DIFF];
          st_nxt.stby_off = pwdata[MISC_STBY];
          st_nxt.t16      = pwdata[MISC_T16_LO +: NUM_XTMR];
        end
        default: begin
        end
      endcase
    end

    // Busy write of one starts on demand
    sw_trig = wr && (paddr == OFS_CTRL) && pwdata[CTRL_BUSY]
              && pwdata[CTRL_EN]
              && (pwdata[CTRL_SRC_LO +: SRC_W] == SRC_SW);

    // Byte overflow picked by timer width
    xtmr = (tmr_ovf.hi & st_r.t16) | (tmr_ovf.lo & ~st_r.t16);

    st_nxt.pin_d = pin_s;
    unique case (st_r.src)
      SRC_SW:  hw_trig = 1'b0;
      SRC_T0:  hw_trig = tmr_ovf.t0;
      SRC_T2:  hw_trig = xtmr[0];
      SRC_T1:  hw_trig = tmr_ovf.t1;
      SRC_PIN: hw_trig = pin_s & ~st_r.pin_d;
      SRC_T3:  hw_trig = xtmr[1];
      SRC_T4:  hw_trig = xtmr[2];
      SRC_T5:  hw_trig = xtmr[3];
    endcase
    trig   = sw_trig | (hw_trig & st_r.en);
    lp_pin = st_r.tm && (st_r.src == SRC_PIN);

    unique case (st_r.fsm)
      SACC_IDLE: begin
        if (trig) begin
          if (st_r.tm && !lp_pin) begin
            st_nxt.fsm     = SACC_TRACK;
            st_nxt.trk_cnt = '0;
          end else begin
            // Tracking mode off, or pin rising edge with tracking on, converts at once
            st_nxt.fsm  = SACC_CONV;
            st_nxt.code = TRIAL_INIT;
            st_nxt.idx  = IDX_MSB;
          end
        end
      end
      SACC_TRACK: begin
        if (sar_tick) begin
          if (st_r.trk_cnt == TRK_LAST) begin
            st_nxt.fsm  = SACC_CONV;
            st_nxt.code = TRIAL_INIT;
            st_nxt.idx  = IDX_MSB;
          end else begin
            st_nxt.trk_cnt = st_r.trk_cnt + 2'h1;
          end
        end
      end
      SACC_CONV: begin
        if (sar_tick) begin
          // Successive approximation, one bit a tick
          if (!cmp_in) begin
            st_nxt.code[st_r.idx] = 1'b0;
          end
          if (st_r.idx == '0) begin
            st_nxt.fsm = SACC_DONE;
          end else begin
            st_nxt.idx        = nidx;
            st_nxt.code[nidx] = 1'b1;
          end
        end
      end
      SACC_DONE: begin
        // Both bytes loaded in one edge
        st_nxt.res = fmt_res;
        // Busy falls as the flag sets
        st_nxt.done = 1'b1;
        st_nxt.fsm  = SACC_IDLE;
      end
    endcase

    // Disabled converter held in shutdown
    // Next enable, so enable and start may share one write
    if (!st_nxt.en) begin
      st_nxt.fsm = SACC_IDLE;
    end

    if (!st_r.en || (st_r.stby_off && standby)) begin
      trk = 1'b0;
    end else if (!st_r.tm) begin
      trk = (st_r.fsm == SACC_IDLE);
    end else if (st_r.src == SRC_PIN) begin
      trk = (st_r.fsm == SACC_IDLE) && !pin_s;
    end else begin
      trk = (st_r.fsm == SACC_TRACK);
    end

    // Read data captured in the setup phase
    unique case (paddr)
      OFS_CTRL: begin
        rdata[CTRL_EN]                = st_r.en;
        rdata[CTRL_TM]                = st_r.tm;
        rdata[CTRL_DONE]              = st_r.done;
        rdata[CTRL_BUSY]              = busy;
        rdata[CTRL_SRC_LO +: SRC_W]   = st_r.src;
      end
      OFS_CFG: begin
        rdata[CFG_DIV_LO +: DIV_W]    = st_r.div;
        rdata[CFG_LJST]               = st_r.ljst;
      end
      OFS_RESH: rdata[7:0] = st_r.res[15:8];
      OFS_RESL: rdata[7:0] = st_r.res[7:0];
      OFS_MISC: begin
        rdata[MISC_DIFF]              = st_r.diff;
        rdata[MISC_STBY]              = st_r.stby_off;
        rdata[MISC_T16_LO +: NUM_XTMR] = st_r.t16;
      end
      default: hit = 1'b0;
    endcase
    if (psel && !penable) begin
      st_nxt.prdata  = rdata;
      st_nxt.pslverr = ~hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{div: CFG_DIV_RST, fsm: SACC_IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready        = 1'b1;
  assign prdata        = st_r.prdata;
  assign pslverr       = st_r.pslverr;
  assign analog_enable = st_r.en;
  assign track_enable  = trk;
  assign sar_strobe    = sar_tick && (st_r.fsm == SACC_CONV);
  assign dac_code      = st_r.code;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_off_shutdown: assert property (
    !analog_enable |-> (st_r.fsm == SACC_IDLE) && !track_enable
                       && !sar_strobe)
    else $error("converter active while disabled");

  a_align_right: assert property (
    (st_r.fsm == SACC_DONE) && !st_r.ljst
    |=> st_r.res[CODE_W-1:0]
        == ($past(st_r.code) ^ {$past(st_r.diff), {(CODE_W-1){1'b0}}}))
    else $error("right-aligned code misplaced");

  a_se_zero_pad: assert property (
    (st_r.fsm == SACC_DONE) && !st_r.diff && !st_r.ljst
    |=> st_r.res[15:10] == 6'h00)
    else $error("single-ended high pad not zero");

  a_lj_zero_pad: assert property (
    (st_r.fsm == SACC_DONE) && st_r.ljst
    |=> st_r.res[5:0] == 6'h00
        && st_r.res[15:6]
        == ($past(st_r.code) ^ {$past(st_r.diff), {(CODE_W-1){1'b0}}}))
    else $error("left-aligned low pad not zero");

  a_sign_extend: assert property (
    (st_r.fsm == SACC_DONE) && st_r.diff && !st_r.ljst
    |=> st_r.res[15:10] == {6{st_r.res[9]}}
        && st_r.res[9] == !$past(st_r.code[9]))
    else $error("differential sign extension wrong");

  a_div_period: assert property (
    sar_tick && st_r.en && (st_r.div == 5'h03)
    ##1 (st_r.en && (st_r.div == 5'h03)) [*4]
    |-> sar_tick && !$past(sar_tick, 1) && !$past(sar_tick, 2)
        && !$past(sar_tick, 3))
    else $error("SAR clock period not divider plus one");

  a_sw_start: assert property (
    sw_trig && (st_r.fsm == SACC_IDLE) |=> busy)
    else $error("software start ignored");

  a_busy_flag: assert property (
    $fell(busy) && st_r.en |-> st_r.done)
    else $error("busy fell without completion flag");

  // Check helper: SAR ticks seen in the current conversion
  logic [IDX_W:0] conv_ticks_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_ticks_r <= '0;
    end else if (st_r.fsm != SACC_CONV) begin
      conv_ticks_r <= '0;
    end else if (sar_tick) begin
      conv_ticks_r <= conv_ticks_r + {{IDX_W{1'b0}}, 1'b1};
    end
  end

  a_conv_len: assert property (
    (st_r.fsm == SACC_CONV) ##1 (st_r.fsm == SACC_DONE)
    |-> conv_ticks_r == (IDX_W+1)'(CODE_W))
    else $error("conversion did not take ten SAR clocks");

  a_track_three: assert property (
    (st_r.fsm == SACC_TRACK) ##1 (st_r.fsm == SACC_CONV)
    |-> $past(st_r.trk_cnt) == TRK_LAST && $past(sar_tick))
    else $error("track window not three SAR clocks");

  a_track_cont: assert property (
    st_r.en && !st_r.tm && !standby |-> track_enable == !busy)
    else $error("default tracking wrong");

  a_pin_track: assert property (
    st_r.en && lp_pin && !(st_r.stby_off && standby)
    && (st_r.fsm == SACC_IDLE) |-> track_enable == !pin_s)
    else $error("pin tracking wrong");

  a_standby_off: assert property (
    st_r.stby_off && standby |-> !track_enable)
    else $error("tracking during standby");

  c_sw_conv: cover property (
    sw_trig ##[1:400] $fell(busy));

  c_pin_lp: cover property (
    lp_pin && (st_r.fsm == SACC_IDLE) && trig ##1 busy);

  c_track_lp: cover property (
    (st_r.fsm == SACC_TRACK) ##[1:200] (st_r.fsm == SACC_CONV));

  c_diff_lj: cover property (
    (st_r.fsm == SACC_DONE) && st_r.diff && st_r.ljst);

endmodule : sacc_top
`default_nettype wire

/* sacc_analog_model.sv */
// Analog front end and timer overflow model facing the converter control
`timescale 1ns/1ps
`default_nettype none
module sacc_analog_model
  import sacc_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Converter side
  input  wire logic              analog_enable,
  input  wire logic [CODE_W-1:0] dac_code,
  output logic                   cmp_in,
  // Bench control
  input  wire logic [CODE_W-1:0] target,
  input  wire logic              tmr_fire,
  input  wire logic [9:0]        tmr_mask,
  output var  sacc_tmr_t         tmr_ovf
);
  logic flip_r;

  // Powered-down comparator gives no stable answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flip_r <= 1'b0;
    end else begin
      flip_r <= ~flip_r;
    end
  end

  assign cmp_in = analog_enable ? (target >= dac_code) : flip_r;

  assign tmr_ovf = tmr_fire ? sacc_tmr_t'(tmr_mask) : '0;
endmodule : sacc_analog_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the converter control
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sacc_pkg::*;
;
  logic              pclk = 1'b0, presetn = 1'b0, chk = 1'b0;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]        paddr = '0;
  logic [31:0]       pwdata = '0, prdata;
  logic              pready, pslverr, cmp_in, analog_enable;
  logic              track_enable, sar_strobe;
  logic [CODE_W-1:0] dac_code, target = '0;
  logic              pin = 1'b0, standby = 1'b0, fire = 1'b0;
  logic [9:0]        mask = '0;
  logic [15:0]       last_e = '0;
  sacc_tmr_t         tmr_ovf;
  logic [32:0]       exp_q[$];
  logic [9:0]        codes[4] = '{10'h3ff, 10'h200, 10'h100, 10'h000};
  int                errors = 0, tests_run = 0, seed;

  always #5 pclk = ~pclk;

  sacc_top u_sacc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .tmr_ovf(tmr_ovf),
    .external_start_pin(pin), .standby(standby), .cmp_in(cmp_in),
    .analog_enable(analog_enable), .track_enable(track_enable),
    .sar_strobe(sar_strobe), .dac_code(dac_code)
  );

  sacc_analog_model u_sacc_analog_model (
    .pclk(pclk), .presetn(presetn), .analog_enable(analog_enable),
    .dac_code(dac_code), .cmp_in(cmp_in), .target(target),
    .tmr_fire(fire), .tmr_mask(mask), .tmr_ovf(tmr_ovf)
  );

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  // Read answers are judged against the oldest queued note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && chk) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic ck,
                     input logic [32:0] ex, output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk <= ck;
    if (ck) exp_q.push_back(ex);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, 1'b0, '0, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] ex);
    logic [31:0] q;
    apb(1'b0, a, '0, 1'b1, ex, q);
  endtask : rd

  task automatic wait_done;
    logic [31:0] q;
    int n;
    q = '0;
    n = 0;
    while (q[CTRL_DONE] !== 1'b1 && n < 300) begin
      apb(1'b0, OFS_CTRL, '0, 1'b0, '0, q);
      n++;
    end
    if (n >= 300) errors++;
  endtask : wait_done

  task automatic pulse(input logic [9:0] m);
    @(posedge pclk);
    fire <= 1'b1;
    mask <= m;
    @(posedge pclk);
    fire <= 1'b0;
  endtask : pulse

  task automatic cnt_track(input int w, output int n);
    n = 0;
    repeat (w) begin
      @(negedge pclk);
      if (track_enable === 1'b1) n++;
    end
  endtask : cnt_track

  function automatic logic [15:0] fe(logic [9:0] c, logic lj, logic df);
    logic [9:0] v;
    v = df ? (c ^ 10'h200) : c;
    return lj ? {v, 6'h00} : {{6{df & v[9]}}, v};
  endfunction : fe

  function automatic logic [9:0] rmask(logic [2:0] s, logic [3:0] t);
    int x;
    x = (s == SRC_T2) ? 0 : int'(s) - 4;
    if (s == SRC_T0) return 10'h200;
    if (s == SRC_T1) return 10'h100;
    if (s == SRC_PIN) return 10'h000;
    return t[x] ? (10'h001 << x) : (10'h010 << x);
  endfunction : rmask

  task automatic conv(logic [9:0] c, logic lj, logic df, logic [4:0] dv,
                      logic tm);
    logic [7:0] cb;
    last_e = fe(c, lj, df);
    cb = {1'b1, tm, 6'h00};
    target <= c;
    wr(OFS_CFG, {24'h0, dv, lj, 2'b0});
    wr(OFS_MISC, {31'h0, df});
    wr(OFS_CTRL, {24'h0, cb | 8'h10});
    wait_done();
    check(33'(dac_code), 33'(c));
    rd(OFS_RESH, {25'h0, last_e[15:8]});
    rd(OFS_RESL, {25'h0, last_e[7:0]});
    rd(OFS_CTRL, {25'h0, cb | 8'h20});
    wr(OFS_CTRL, {24'h0, cb});
  endtask : conv

  task automatic close_out;
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  initial begin
    #200_000;
    errors++;
    close_out();
  end

  initial begin : main
    logic [31:0] r;
    logic [9:0]  rm;
    int          n;
    seed = $urandom(55);
    repeat (20) @(posedge pclk);
    check(analog_enable, 1'b0);
    presetn <= 1'b1;
    rd(OFS_CTRL, 33'h0);
    rd(OFS_CFG, 33'hf8);
    rd(OFS_RESH, 33'h0);
    rd(8'h14, 33'h1_0000_0000);
    wr(OFS_RESH, 32'h55);
    rd(OFS_RESH, 33'h0);
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        conv(codes[k], m[0], m[1], 5'h00, 1'b0);
      end
    end
    repeat (8) begin
      r = $urandom;
      conv(r[9:0], r[10], r[11], {3'h0, r[13:12]}, r[14]);
    end
    // Tick spacing, busy reading and abort on disable
    wr(OFS_CFG, 32'h20);
    wr(OFS_CTRL, 32'h90);
    rd(OFS_CTRL, 33'h90);
    n = 0;
    while (sar_strobe !== 1'b1 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (sar_strobe !== 1'b1 && n < 100);
    check(33'(n), 33'd5);
    wr(OFS_CTRL, 32'h00);
    @(negedge pclk);
    check(analog_enable, 1'b0);
    rd(OFS_CTRL, 33'h0);
    rd(OFS_RESH, {25'h0, last_e[15:8]});
    wr(OFS_CTRL, 32'h01);
    pulse(10'h200);
    repeat (20) @(negedge pclk);
    rd(OFS_CTRL, 33'h01);
    for (int s = 1; s < 8; s++) begin
      r = $urandom;
      rm = rmask(s[2:0], r[3:0]);
      wr(OFS_MISC, {26'h0, r[3:0], 2'h0});
      wr(OFS_CTRL, 32'h80 | 32'(s));
      pulse(~rm);
      repeat (20) @(negedge pclk);
      rd(OFS_CTRL, 33'h80 | 33'(s));
      if (s == 4) begin
        @(posedge pclk);
        pin <= 1'b1;
      end else begin
        pulse(rm);
      end
      wait_done();
      rd(OFS_CTRL, 33'ha0 | 33'(s));
      @(posedge pclk);
      pin <= 1'b0;
      wr(OFS_CTRL, 32'h80 | 32'(s));
    end
    // Track and hold behaviour in both modes
    wr(OFS_CFG, 32'h0);
    wr(OFS_MISC, 32'h0);
    wr(OFS_CTRL, 32'h80);
    repeat (2) @(negedge pclk);
    check(track_enable, 1'b1);
    wr(OFS_CTRL, 32'h90);
    cnt_track(8, n);
    check(33'(n), 33'd0);
    wait_done();
    wr(OFS_CTRL, 32'h80);
    wr(OFS_MISC, 32'h2);
    @(posedge pclk);
    standby <= 1'b1;
    repeat (3) @(negedge pclk);
    check(track_enable, 1'b0);
    @(posedge pclk);
    standby <= 1'b0;
    repeat (3) @(negedge pclk);
    check(track_enable, 1'b1);
    wr(OFS_CTRL, 32'hc0);
    repeat (2) @(negedge pclk);
    check(track_enable, 1'b0);
    wr(OFS_CTRL, 32'hd0);
    cnt_track(20, n);
    check(33'(n), 33'd3);
    wait_done();
    wr(OFS_CTRL, 32'hc4);
    repeat (4) @(negedge pclk);
    check(track_enable, 1'b1);
    @(posedge pclk);
    pin <= 1'b1;
    repeat (6) @(negedge pclk);
    check(track_enable, 1'b0);
    wait_done();
    rd(OFS_CTRL, 33'he4);
    close_out();
  end
endmodule : testbench
`default_nettype wire
